// *** common/ccc_pkg.sv ***
// constants, types and register map of the capture/compare channel unit
// Contract
// RULE1: in capture mode a pin event copies the assigned timer into the channel register.
// RULE2: every capture also raises the interrupt request of that channel.
// RULE3: capture trigger per channel: rising only, falling only, or both edges.
// RULE4: compare channels check register against timer each count; match fires mode action.
// RULE5: mode two raises interrupt only, pin untouched, at most once per period.
// RULE6: mode three drives pin high on match, low on overflow, once per period.
// RULE7: double register mode: two registers share one pin that toggles on each match.
// RULE8: single event option limits any compare mode to one edge or pulse.
// RULE9: each channel pin is capture input or compare output, so it is bidirectional.
// RULE10: overflow rearms the per-period limit; single event stops until reconfigured.
// RULE11: outside sources hold each capture pin level for at least one clock.
package ccc_pkg;

    // ==========================================
    // sizes
    localparam int NCH = 7;
    localparam int TW = 16;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int NTMR = 2;
    localparam logic [2:0] NCH_L = 3'h7;
    localparam logic [TW-1:0] TMR_MAX = 16'hFFFF;
    localparam logic [TW-1:0] TMR_ONE = 16'h0001;

    // ==========================================
    // register map, byte addresses
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_TMR0 = 8'h04;
    localparam logic [AW-1:0] ADDR_TMR1 = 8'h08;
    localparam logic [AW-1:0] ADDR_STAT = 8'h0C;
    localparam logic [AW-1:0] ADDR_MASK = 8'h10;
    localparam logic [2:0] REGION_VAL = 3'h2;
    localparam logic [2:0] REGION_CFG = 3'h4;
    localparam int CFG_DONE_BIT = 8;
    localparam int CFG_W = 7;

    // ==========================================
    // channel modes and capture edges
    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_CAPTURE = 3'b001,
        MODE_CMP0 = 3'b010,
        MODE_CMP1 = 3'b011,
        MODE_CMP2 = 3'b100,
        MODE_CMP3 = 3'b101,
        MODE_DOUBLE = 3'b110
    } ccc_mode_e;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } ccc_edge_e;

    typedef struct packed {
        logic single;
        logic tsel;
        ccc_edge_e edge_sel;
        ccc_mode_e mode;
    } ccc_cfg_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } ccc_bus_s;

    typedef struct packed {
        logic [NCH-1:0] out;
        logic [NCH-1:0] oe_n;
    } ccc_pin_s;

endpackage

// *** hw/ccc_unit.sv ***
// capture/compare channel bank with two free-running timers
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module ccc_unit import ccc_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire ccc_bus_s bus_i,
    output logic [DW-1:0] bus_rdata_o,
    input wire logic [NCH-1:0] channel_pin_i,
    output ccc_pin_s channel_pin_o,
    output logic irq_o
);

    // ==========================================
    // decode helpers
    // channel register window hit, one word per channel
    function automatic logic chan_hit(input logic [AW-1:0] a, input logic [2:0] region,
                                      input int c);
        return (a[7:5] == region) && (a[4:2] < NCH_L) && (a[4:2] == 3'(c));
    endfunction

    function automatic logic is_cmp(input ccc_mode_e m);
        return (m == MODE_CMP0) || (m == MODE_CMP1) || (m == MODE_CMP2) ||
               (m == MODE_CMP3) || (m == MODE_DOUBLE);
    endfunction

    // ==========================================
    // timers
    logic [NTMR-1:0] run_q, run_d;
    logic [TW-1:0] tmr_q [NTMR];
    logic [TW-1:0] tmr_d [NTMR];
    logic [NTMR-1:0] ovf;

    // free running up counters, loadable by software
    always_comb begin
        run_d = run_q;
        if (bus_i.wr && bus_i.addr == ADDR_CTRL) begin
            run_d = bus_i.wdata[NTMR-1:0];
        end
        for (int t = 0; t < NTMR; t++) begin
            ovf[t] = run_q[t] && (tmr_q[t] == TMR_MAX);
            tmr_d[t] = run_q[t] ? tmr_q[t] + TMR_ONE : tmr_q[t];
        end
        if (bus_i.wr && bus_i.addr == ADDR_TMR0) begin
            tmr_d[0] = bus_i.wdata[TW-1:0];
        end
        if (bus_i.wr && bus_i.addr == ADDR_TMR1) begin
            tmr_d[1] = bus_i.wdata[TW-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q <= '0;
            for (int t = 0; t < NTMR; t++) begin
                tmr_q[t] <= '0;
            end
        end else begin
            run_q <= run_d;
            tmr_q <= tmr_d;
        end
    end

    // ==========================================
    // channels
    ccc_cfg_s cfg_q [NCH];
    ccc_cfg_s cfg_d [NCH];
    logic [TW-1:0] val_q [NCH];
    logic [TW-1:0] val_d [NCH];
    logic [NCH-1:0] done_q, done_d, armed_q, armed_d, pin_q, pin_d, prev_q, prev_d;
    logic [NCH-1:0] cap_evt, match, act, tov, oe_n;
    logic [TW-1:0] tv [NCH];

    // capture edge detect, compare match and per-channel action
    always_comb begin
        prev_d = channel_pin_i;
        for (int c = 0; c < NCH; c++) begin
            tv[c] = tmr_q[cfg_q[c].tsel];
            tov[c] = ovf[cfg_q[c].tsel];
            // pins are taken as synchronous; a level held one clock is seen
            cap_evt[c] = (cfg_q[c].mode == MODE_CAPTURE) &&                      // RULE11
                         ((cfg_q[c].edge_sel[0] && channel_pin_i[c] && !prev_q[c]) || // RULE3
                          (cfg_q[c].edge_sel[1] && !channel_pin_i[c] && prev_q[c]));
            match[c] = run_q[cfg_q[c].tsel] && (tv[c] == val_q[c]);              // RULE4
            act[c] = match[c] && is_cmp(cfg_q[c].mode) && !done_q[c] &&
                     (armed_q[c] || !((cfg_q[c].mode == MODE_CMP2) ||
                                      (cfg_q[c].mode == MODE_CMP3)));           // RULE5 RULE6
        end
        for (int c = 0; c < NCH; c++) begin
            cfg_d[c] = cfg_q[c];
            val_d[c] = val_q[c];
            done_d[c] = done_q[c];
            armed_d[c] = armed_q[c];
            pin_d[c] = pin_q[c];
            oe_n[c] = 1'b1;
            if (cap_evt[c]) begin
                val_d[c] = tv[c];                                                // RULE1
            end else if (bus_i.wr && chan_hit(bus_i.addr, REGION_VAL, c)) begin
                val_d[c] = bus_i.wdata[TW-1:0];
            end
            // overflow starts a new period, so the once-per-period limit rearms
            if (tov[c]) begin
                armed_d[c] = 1'b1;                                               // RULE10
            end else if (act[c]) begin
                armed_d[c] = 1'b0;
            end
            if (act[c] && cfg_q[c].single) begin
                done_d[c] = 1'b1;                                                // RULE8
            end
            case (cfg_q[c].mode)
                MODE_CMP1: begin
                    oe_n[c] = 1'b0;                                              // RULE9
                    if (act[c]) begin
                        pin_d[c] = !pin_q[c];
                    end
                end
                MODE_CMP3: begin
                    oe_n[c] = 1'b0;
                    if (act[c]) begin
                        pin_d[c] = 1'b1;                                         // RULE6
                    end else if (tov[c]) begin
                        pin_d[c] = 1'b0;                                         // RULE6
                    end
                end
                MODE_DOUBLE: begin
                    // even channel owns the pin; odd partner is only a second register
                    if (c % 2 == 0) begin
                        oe_n[c] = 1'b0;
                        if (act[c] || (c + 1 < NCH && act[(c + 1) % NCH] &&
                                       cfg_q[(c + 1) % NCH].mode == MODE_DOUBLE)) begin
                            pin_d[c] = !pin_q[c];                                // RULE7
                        end
                    end
                end
                default: begin
                    oe_n[c] = 1'b1;                                              // RULE5 RULE9
                end
            endcase
            // reconfiguration clears single-event lockout and rearms
            if (bus_i.wr && chan_hit(bus_i.addr, REGION_CFG, c)) begin
                cfg_d[c] = ccc_cfg_s'(bus_i.wdata[CFG_W-1:0]);
                done_d[c] = 1'b0;                                                // RULE10
                armed_d[c] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < NCH; c++) begin
                cfg_q[c] <= '0;
                val_q[c] <= '0;
            end
            done_q <= '0;
            armed_q <= '1;
            pin_q <= '0;
            prev_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            val_q <= val_d;
            done_q <= done_d;
            armed_q <= armed_d;
            pin_q <= pin_d;
            prev_q <= prev_d;
        end
    end

    assign channel_pin_o.out = pin_q;
    assign channel_pin_o.oe_n = oe_n;

    // ==========================================
    // interrupt status, mask and register read
    logic [NCH-1:0] stat_q, stat_d, mask_q, mask_d, evt;
    logic [DW-1:0] rdata_q, rdata_d;

    // read of status clears it, but a new event in that cycle still sets
    always_comb begin
        evt = cap_evt | act;                                                     // RULE2
        stat_d = stat_q;
        if (bus_i.rd && bus_i.addr == ADDR_STAT) begin
            stat_d = '0;
        end
        stat_d = stat_d | evt;
        mask_d = mask_q;
        if (bus_i.wr && bus_i.addr == ADDR_MASK) begin
            mask_d = bus_i.wdata[NCH-1:0];
        end
        rdata_d = '0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                ADDR_CTRL: rdata_d = DW'(run_q);
                ADDR_TMR0: rdata_d = DW'(tmr_q[0]);
                ADDR_TMR1: rdata_d = DW'(tmr_q[1]);
                ADDR_STAT: rdata_d = DW'(stat_q);
                ADDR_MASK: rdata_d = DW'(mask_q);
                default: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (chan_hit(bus_i.addr, REGION_VAL, c)) begin
                            rdata_d = DW'(val_q[c]);
                        end
                        if (chan_hit(bus_i.addr, REGION_CFG, c)) begin
                            rdata_d = DW'(cfg_q[c]);
                            rdata_d[CFG_DONE_BIT] = done_q[c];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= '0;
            mask_q <= '0;
            rdata_q <= '0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata_o = rdata_q;
    assign irq_o = |(stat_q & mask_q);

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // per channel properties, one copy for each channel
    for (genvar g = 0; g < NCH; g++) begin : g_chk
        capture_latch_a: assert property ( // RULE1
            cap_evt[g] && !bus_i.wr |=> val_q[g] == $past(tv[g]))
            else $error("capture did not latch timer");
        capture_irq_a: assert property ( // RULE2
            cap_evt[g] |=> stat_q[g])
            else $error("capture lost its interrupt");
        capture_edge_a: assert property ( // RULE3
            cap_evt[g] && cfg_q[g].edge_sel == EDGE_RISE |-> channel_pin_i[g] && !prev_q[g])
            else $error("rising-only capture fired on other edge");
        compare_match_a: assert property ( // RULE4
            act[g] |-> tv[g] == val_q[g] && is_cmp(cfg_q[g].mode))
            else $error("compare action without match");
        mode2_once_a: assert property ( // RULE5
            act[g] && cfg_q[g].mode == MODE_CMP2 && !tov[g] && !bus_i.wr
            ##1 cfg_q[g].mode == MODE_CMP2 |-> !act[g] && oe_n[g])
            else $error("mode two fired twice in a period");
        mode3_pin_a: assert property ( // RULE6
            cfg_q[g].mode == MODE_CMP3 && !bus_i.wr && tov[g] && !act[g] |=> !pin_q[g])
            else $error("mode three pin not cleared on overflow");
        single_stop_a: assert property ( // RULE8
            act[g] && cfg_q[g].single && !bus_i.wr |=> !act[g] [*2])
            else $error("single event repeated");
        capture_input_a: assert property ( // RULE9
            cfg_q[g].mode == MODE_CAPTURE |-> channel_pin_o.oe_n[g])
            else $error("capture pin is driven");
        rearm_ovf_a: assert property ( // RULE10
            tov[g] |=> armed_q[g])
            else $error("overflow did not rearm");
        // compare side: status, pin drive, lockout and rearm; then capture hold and falling edge
        compare_status_a: assert property ( // RULE4
            act[g] |=> stat_q[g])
            else $error("compare action lost its interrupt");
        toggle_mode_a: assert property ( // RULE4
            act[g] && cfg_q[g].mode == MODE_CMP1 |=> pin_q[g] != $past(pin_q[g]))
            else $error("toggle mode pin did not invert");
        mode2_undriven_a: assert property ( // RULE5
            cfg_q[g].mode == MODE_CMP2 |-> channel_pin_o.oe_n[g])
            else $error("mode two drives its pin");
        mode3_high_a: assert property ( // RULE6
            act[g] && cfg_q[g].mode == MODE_CMP3 |=> pin_q[g])
            else $error("mode three pin not set on match");
        single_done_a: assert property ( // RULE8
            act[g] && cfg_q[g].single && !bus_i.wr |=> done_q[g])
            else $error("single event not locked out");
        compare_drive_a: assert property ( // RULE9
            cfg_q[g].mode == MODE_CMP1 || cfg_q[g].mode == MODE_CMP3 |-> !channel_pin_o.oe_n[g])
            else $error("compare pin not driven");
        config_rearm_a: assert property ( // RULE10
            bus_i.wr && chan_hit(bus_i.addr, REGION_CFG, g) |=> !done_q[g] && armed_q[g])
            else $error("config write did not rearm");
        capture_hold_a: assert property ( // RULE1
            cfg_q[g].mode == MODE_CAPTURE && !cap_evt[g] && !bus_i.wr
            |=> val_q[g] == $past(val_q[g]))
            else $error("capture value changed without event");
        capture_fall_a: assert property ( // RULE3
            cap_evt[g] && cfg_q[g].edge_sel == EDGE_FALL |-> !channel_pin_i[g] && prev_q[g])
            else $error("falling-only capture fired on other edge");
    end

    double_toggle_a: assert property ( // RULE7
        cfg_q[0].mode == MODE_DOUBLE && cfg_q[1].mode == MODE_DOUBLE && !bus_i.wr &&
        (act[0] || act[1]) |=> pin_q[0] != $past(pin_q[0]))
        else $error("double register pin did not toggle");

    // bus side: a status read keeps only the events of that same cycle; then the odd double partner stays undriven
    status_clear_a: assert property ( // RULE2
        bus_i.rd && bus_i.addr == ADDR_STAT |=> stat_q == $past(evt))
        else $error("status read did not clear");
    double_odd_a: assert property ( // RULE7
        cfg_q[1].mode == MODE_DOUBLE |-> channel_pin_o.oe_n[1])
        else $error("odd double partner drives its pin");

endmodule

// *** testbench/ccc_pin_model.sv ***
// far side of the channel pins: outside sources and the resolved wire level
`timescale 1ns/1ps
module ccc_pin_model import ccc_pkg::*; (
    input wire logic ref_clk_i,
    input wire ccc_pin_s dev_i,
    input wire logic [NCH-1:0] ext_en_i,
    input wire logic [NCH-1:0] ext_lvl_i,
    output logic [NCH-1:0] pin_o
);
    logic [NCH-1:0] lvl_q = '0;
    logic [NCH-1:0] en_q = '0;
    logic [NCH-1:0] last_q = '0;

    // ==========================================
    // source levels change only on clock edges, so each lasts a full clock
    always @(posedge ref_clk_i) begin
        lvl_q <= ext_lvl_i;
        en_q <= ext_en_i;
        last_q <= pin_o;
    end

    // wire level: device drive wins; a released line keeps flipping, no pull exists
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            if (!dev_i.oe_n[c]) begin
                pin_o[c] = dev_i.out[c];
            end else if (en_q[c]) begin
                pin_o[c] = lvl_q[c];
            end else begin
                pin_o[c] = ~last_q[c];
            end
        end
    end
endmodule

// *** testbench/capture_compare_channel_unit_test.sv ***
// self-checking bench of the capture/compare channel unit
`timescale 1ns/1ps
module capture_compare_channel_unit_test import ccc_pkg::*; ();
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    ccc_bus_s bus = '0;
    logic [DW-1:0] rdata;
    ccc_pin_s pin_dev;
    logic [NCH-1:0] pin_wire;
    logic [NCH-1:0] ext_en = '0;
    logic [NCH-1:0] ext_lvl = '0;
    logic irq;
    int err_count = 0;
    int samples_checked = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    ccc_unit DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .bus_rdata_o(rdata),
        .channel_pin_i(pin_wire), .channel_pin_o(pin_dev), .irq_o(irq));
    ccc_pin_model far (.ref_clk_i(ref_clk_i), .dev_i(pin_dev), .ext_en_i(ext_en),
        .ext_lvl_i(ext_lvl), .pin_o(pin_wire));

    // ==========================================
    // helpers
    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk_i);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_i);
        bus.wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge ref_clk_i);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge ref_clk_i);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic pins(input logic [NCH-1:0] en, input logic [NCH-1:0] lvl);
        @(posedge ref_clk_i);
        ext_en <= en;
        ext_lvl <= lvl;
    endtask

    task automatic wait_cy(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    function automatic logic [DW-1:0] cfgw(ccc_mode_e m, ccc_edge_e e, logic t, logic s);
        ccc_cfg_s c;
        c = '{single: s, tsel: t, edge_sel: e, mode: m};
        return DW'(c);
    endfunction

    function automatic logic [AW-1:0] va(int c);
        return 8'h40 + AW'(4 * c);
    endfunction

    function automatic logic [AW-1:0] ca(int c);
        return 8'h80 + AW'(4 * c);
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #(40 * 5000);
        err_count++;
        results();
    end

    // ==========================================
    // main sequence
    initial begin
        logic [TW-1:0] r1;
        logic [TW-1:0] r2;
        void'($urandom(83338));
        r1 = TW'($urandom());
        r2 = TW'($urandom());
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        #1 chk(pin_dev.oe_n, 32'h7F);
        chk(irq, 32'h0);
        rdc(ADDR_MASK, 32'h0);
        rdc(8'hFC, 32'h0);
        // capture on a stopped timer so the latched value is known exactly
        pins(7'h07, 7'h00);
        wr(ADDR_TMR0, DW'(r1));
        wr(ADDR_MASK, 32'h7F);
        wr(ca(0), cfgw(MODE_CAPTURE, EDGE_RISE, 1'b0, 1'b0));
        wr(ca(1), cfgw(MODE_CAPTURE, EDGE_FALL, 1'b0, 1'b0));
        wr(ca(2), cfgw(MODE_CAPTURE, EDGE_BOTH, 1'b0, 1'b0));
        pins(7'h07, 7'h07);
        wait_cy(6);
        chk(irq, 32'h1);
        chk(pin_dev.oe_n[2:0], 32'h7);
        rdc(va(0), DW'(r1));
        rdc(va(1), 32'h0);
        rdc(va(2), DW'(r1));
        rdc(ADDR_STAT, 32'h5);
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_TMR0, DW'(r2));
        pins(7'h07, 7'h00);
        wait_cy(6);
        chk(irq, 32'h0);
        rdc(va(0), DW'(r1));
        rdc(va(1), DW'(r2));
        rdc(va(2), DW'(r2));
        rdc(ADDR_STAT, 32'h6);
        // compare modes on timer one, started just below the match values
        wr(ADDR_MASK, 32'h18);
        wr(va(3), 32'hFFF0);
        wr(va(4), 32'hFFE8);
        wr(va(6), 32'hFFE4);
        wr(ca(3), cfgw(MODE_CMP3, EDGE_NONE, 1'b1, 1'b0));
        wr(ca(4), cfgw(MODE_CMP2, EDGE_NONE, 1'b1, 1'b0));
        wr(ca(6), cfgw(MODE_CMP1, EDGE_NONE, 1'b1, 1'b1));
        wr(va(5), 32'hFFEC);
        wr(ca(5), cfgw(MODE_CMP0, EDGE_NONE, 1'b1, 1'b0));
        wr(ADDR_TMR1, 32'hFFE0);
        wr(ADDR_CTRL, 32'h2);
        wait_cy(8);
        chk(pin_dev.out[3], 32'h0);
        wait_cy(12);
        chk(pin_dev.out[3], 32'h1);
        chk(pin_dev.oe_n[4], 32'h1);
        chk(pin_dev.oe_n[5], 32'h1);
        chk(pin_dev.out[6], 32'h1);
        chk(irq, 32'h1);
        rdc(ADDR_STAT, 32'h78);
        // same matches again without an overflow: only the plain compare repeats
        wr(ADDR_TMR1, 32'hFFE0);
        wait_cy(20);
        rdc(ADDR_STAT, 32'h20);
        chk(pin_dev.out[6], 32'h1);
        wait_cy(30);
        chk(pin_dev.out[3], 32'h0);
        wr(ADDR_TMR1, 32'hFFE0);
        wait_cy(20);
        chk(pin_dev.out[3], 32'h1);
        rdc(ADDR_STAT, 32'h38);
        rdc(ca(6), cfgw(MODE_CMP1, EDGE_NONE, 1'b1, 1'b1) | 32'h100);
        // rewriting the config clears the single-event lockout
        wr(ca(6), cfgw(MODE_CMP1, EDGE_NONE, 1'b1, 1'b1));
        rdc(ca(6), cfgw(MODE_CMP1, EDGE_NONE, 1'b1, 1'b1));
        // double register pair on the even pin; pins stay held until the pair
        // leaves capture mode, else a capture would beat the value write
        wr(va(0), 32'hFFE4);
        wr(va(1), 32'hFFF0);
        wr(ca(0), cfgw(MODE_DOUBLE, EDGE_NONE, 1'b1, 1'b0));
        wr(ca(1), cfgw(MODE_DOUBLE, EDGE_NONE, 1'b1, 1'b0));
        pins(7'h04, 7'h00);
        wr(ADDR_TMR1, 32'hFFE0);
        wait_cy(10);
        chk(pin_dev.out[0], 32'h1);
        chk(pin_dev.oe_n[1:0], 32'h2);
        chk(pin_dev.out[6], 32'h0);
        wait_cy(12);
        chk(pin_dev.out[0], 32'h0);
        chk(pin_dev.out[6], 32'h0);
        results();
    end
endmodule
